// file: src/pie_controller.sv
/*
  Peripheral interrupt expander top: gathers the peripheral request levels, drives the gated
  request bits out unregistered, registers the acknowledge bit word, pulses three maskable CPU lines and loads the
  peripheral vector of the acknowledged source into the vector readback register.
  Assumes peripherals hold their request level until cleared by software or by the
  acknowledge strobe given back here, and the CPU presents its vector address with ack.
*/
// Functional notes
// R1: reset and watchdog go to 0000h, emulator trap to 0026h, nmi to 0024h, none maskable.
// R2: power protection is maskable, on line one (0002h), bit 0.0, vector 0020h, top rank.
// R3: high-priority converter request is on line one, bit 0.1, vector 0004h, priority 5.
// R4: external pin requests a and b are on line one at bits 0.2 and 0.3, vectors 0001h, 0011h.
// R5: spi is bit 0.4 vector 0005h, then sci receive bit 0.5 vector 0006h, on line one.
// R6: sci transmit bit 0.6 vector 0007h, can mailbox 0.7/0040h, can error 0.8/0041h, line one.
// R7: line two (0004h) holds compares at 0.9-0.11 vectors 0021h-0023h, timer-a period 0.12/0027h.
// R8: timer-a compare, underflow, overflow are bits 0.13-0.15 with vectors 0028h, 0029h, 002Ah.
// R9: line three (0006h) holds timer-b period at 1.0/002Bh and timer-b compare at 1.1/002Ch.
// R10: timer-b underflow is bit 1.2/002Dh and timer-b overflow is bit 1.3/002Eh on line three.
// R11: each source has a fixed overall priority, 1 most urgent, lower number served first.
// R12: each cpu line is an active-low two-cycle pulse started when a mapped request goes active.
// R13: an acknowledge clears only the top pending request and re-pulses if others remain.
// R14: on acknowledge the winner's peripheral vector is loaded into the vector register.
// R15: an acknowledge with nothing pending on that line loads phantom vector 0000h.
// R16: the acknowledged line is decoded from the vector address presented with the ack.
`timescale 1ns/10ps
module pie_controller
  import pie_pkg::*;
#(
  parameter int PULSE_CYCLES = PIE_LINE_PULSE_CYCLES
)
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire pie_src_type PERIPH_REQ,
  input wire logic HP_CONVERTER,
  input wire logic HP_EXT_A,
  input wire logic HP_EXT_B,
  input wire logic HP_SPI,
  input wire logic HP_SCI_RX,
  input wire logic HP_SCI_TX,
  input wire logic HP_CAN_MBOX,
  input wire logic HP_CAN_ERR,
  input wire pie_ack_type CPU_ACK,
  output logic CPU_LINE_FIRST_N,
  output logic CPU_LINE_SECOND_N,
  output logic CPU_LINE_THIRD_N,
  output logic [PIE_NUM_SRC-1:0] PERIPHERAL_REQUEST_BITS,
  output logic [PIE_NUM_SRC-1:0] PERIPHERAL_ACK_BITS,
  output logic [PIE_VEC_W-1:0] VECTOR_READBACK_REG,
  output logic ACK_LINE_FIXED
);

  initial
  begin
    if (PIE_NUM_LINES != 3)
      $error("pie_controller: only three mapped lines are served");
    if (PIE_FIRST_LO != 0 || PIE_SECOND_LO != PIE_FIRST_HI + 1 || PIE_THIRD_LO != PIE_SECOND_HI + 1)
      $error("pie_controller: line ranges must be contiguous");
    if (PIE_THIRD_HI != PIE_NUM_SRC - 1)
      $error("pie_controller: line ranges must cover every source");
    if ($bits(pie_src_type) != PIE_NUM_SRC)
      $error("pie_controller: request struct width differs from source count");
    if (PIE_VEC_W != 16)
      $error("pie_controller: vector table entries are 16 bits");
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15)
      $error("pie_controller: PULSE_CYCLES out of range");
  end

  // reset release through two flops
  // every flop behind these two leaves reset on the same edge, whatever the phase of the pin's release
  logic rst_sync1_reg;
  logic rst_sync2_reg;

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync2_reg;

  function automatic logic [1:0] pie_decode_line(input logic [15:0] addr);
    logic [1:0] line;
    line = 2'h3;
    unique case (addr) // R16
      PIE_LINE_FIRST_VEC: line = 2'h0;
      PIE_LINE_SECOND_VEC: line = 2'h1;
      PIE_LINE_THIRD_VEC: line = 2'h2;
      default: line = 2'h3;
    endcase
    return line;
  endfunction

  // fixed, unmaskable entries are handled by the core; flag them for observation
  function automatic logic pie_is_fixed(input logic [15:0] addr);
    return (addr == PIE_RESET_VEC) || (addr == PIE_EMU_TRAP_VEC) || (addr == PIE_NMI_VEC); // R1
  endfunction

  // true when any bit of the slice [lo, hi] is set
  function automatic logic pie_any_in(input logic [PIE_NUM_SRC-1:0] bits, input int lo,
    input int hi);
    logic found;
    found = 1'b0;
    for (int i = 0; i < PIE_NUM_SRC; i++)
      if (i >= lo && i <= hi)
        found = found | bits[i];
    return found;
  endfunction

  // the bit layout follows the struct, msb first, so reverse into index order
  logic [PIE_NUM_SRC-1:0] raw_req;
  logic [PIE_NUM_SRC-1:0] hp_gate;

  always_comb
  begin
    for (int i = 0; i < PIE_NUM_SRC; i++)
      raw_req[i] = PERIPH_REQ[PIE_NUM_SRC-1-i];
    hp_gate = '1;
    // low-priority-mode requests belong to lines not served here
    hp_gate[PIE_BIT_CONVERTER] = HP_CONVERTER; // R3
    hp_gate[PIE_BIT_EXT_A] = HP_EXT_A; // R4
    hp_gate[PIE_BIT_EXT_B] = HP_EXT_B; // R4
    hp_gate[PIE_BIT_SPI] = HP_SPI; // R5
    hp_gate[PIE_BIT_SCI_RX] = HP_SCI_RX; // R5
    hp_gate[PIE_BIT_SCI_TX] = HP_SCI_TX; // R6
    hp_gate[PIE_BIT_CAN_MBOX] = HP_CAN_MBOX; // R6
    hp_gate[PIE_BIT_CAN_ERR] = HP_CAN_ERR; // R6
  end

  logic [PIE_NUM_SRC-1:0] req_live;
  assign req_live = raw_req & hp_gate; // R2 R7 R8 R9 R10

  logic any_first;
  logic any_second;
  logic any_third;
  logic [4:0] win_first;
  logic [4:0] win_second;
  logic [4:0] win_third;

  pie_winner #(.LO(PIE_FIRST_LO), .HI(PIE_FIRST_HI)) u_win_first
  (
    .req(req_live),
    .any(any_first),
    .index(win_first)
  );

  pie_winner #(.LO(PIE_SECOND_LO), .HI(PIE_SECOND_HI)) u_win_second
  (
    .req(req_live),
    .any(any_second),
    .index(win_second)
  );

  pie_winner #(.LO(PIE_THIRD_LO), .HI(PIE_THIRD_HI)) u_win_third
  (
    .req(req_live),
    .any(any_third),
    .index(win_third)
  );

  // a request joining a line that is already pending must still pulse, so each bit is
  // edge-detected instead of the or of the line
  logic [PIE_NUM_SRC-1:0] req_prev_reg;
  logic [PIE_NUM_SRC-1:0] req_prev_next;
  logic [PIE_NUM_SRC-1:0] req_rise;
  logic [2:0] fresh_line;

  always_comb
  begin
    req_prev_next = req_live;
    req_rise = req_live & ~req_prev_reg; // R12
    fresh_line[0] = pie_any_in(req_rise, PIE_FIRST_LO, PIE_FIRST_HI);
    fresh_line[1] = pie_any_in(req_rise, PIE_SECOND_LO, PIE_SECOND_HI);
    fresh_line[2] = pie_any_in(req_rise, PIE_THIRD_LO, PIE_THIRD_HI);
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      req_prev_reg <= '0;
    else
      req_prev_reg <= req_prev_next;
  end

  // acknowledge decode and vector load
  logic [PIE_VEC_W-1:0] vector_reg;
  logic [PIE_VEC_W-1:0] vector_next;
  logic [PIE_NUM_SRC-1:0] ack_bits_reg;
  logic [PIE_NUM_SRC-1:0] ack_bits_next;
  logic fixed_reg;
  logic fixed_next;
  logic [2:0] line_ack;

  always_comb
  begin
    logic [1:0] line;
    logic hit;
    logic [4:0] idx;
    line = pie_decode_line(CPU_ACK.address);
    hit = 1'b0;
    idx = 5'h00;
    vector_next = vector_reg;
    ack_bits_next = '0;
    line_ack = 3'b000;
    fixed_next = CPU_ACK.valid && pie_is_fixed(CPU_ACK.address); // R1
    if (CPU_ACK.valid)
    begin
      unique case (line)
        2'h0:
        begin
          hit = any_first;
          idx = win_first;
          line_ack = 3'b001;
        end
        2'h1:
        begin
          hit = any_second;
          idx = win_second;
          line_ack = 3'b010;
        end
        2'h2:
        begin
          hit = any_third;
          idx = win_third;
          line_ack = 3'b100;
        end
        default:
        begin
          hit = 1'b0;
          idx = 5'h00;
          line_ack = 3'b000;
        end
      endcase
      if (line != 2'h3)
      begin
        if (hit)
        begin
          vector_next = PIE_PERIPH_VEC[idx]; // R14
          ack_bits_next[idx] = 1'b1; // R13
        end
        else
          vector_next = PIE_PHANTOM_VEC; // R15
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vector_reg <= PIE_VECTOR_RESET;
      ack_bits_reg <= '0;
      fixed_reg <= 1'b0;
    end
    else
    begin
      vector_reg <= vector_next;
      ack_bits_reg <= ack_bits_next;
      fixed_reg <= fixed_next;
    end
  end

  pie_line_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse_first
  (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .pending(any_first),
    .fresh(fresh_line[0]),
    .ack(line_ack[0]),
    .line_n(CPU_LINE_FIRST_N)
  );

  pie_line_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse_second
  (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .pending(any_second),
    .fresh(fresh_line[1]),
    .ack(line_ack[1]),
    .line_n(CPU_LINE_SECOND_N)
  );

  pie_line_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse_third
  (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .pending(any_third),
    .fresh(fresh_line[2]),
    .ack(line_ack[2]),
    .line_n(CPU_LINE_THIRD_N)
  );

  assign PERIPHERAL_REQUEST_BITS = req_live;
  assign PERIPHERAL_ACK_BITS = ack_bits_reg;
  assign VECTOR_READBACK_REG = vector_reg;
  assign ACK_LINE_FIXED = fixed_reg;

endmodule

// file: src/pie_line_pulse.sv
/*
  One CPU line pulser: emits an active-low request of a fixed number of cycles when
  any request of the line rises, or re-fires after an acknowledge while still pending.
  Assumes pending and ack are synchronous to clk.
*/
`timescale 1ns/10ps
module pie_line_pulse
  import pie_pkg::*;
#(
  parameter int PULSE_CYCLES = PIE_LINE_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pending,
  input wire logic fresh,
  input wire logic ack,
  output logic line_n
);

  initial
  begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15)
      $error("pie_line_pulse: PULSE_CYCLES out of range");
  end

  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic ack_seen_reg;
  logic ack_seen_next;

  always_comb
  begin
    count_next = count_reg;
    ack_seen_next = ack;
    if (count_reg != 4'h0)
      count_next = count_reg - 4'h1;
    else if (fresh || (ack_seen_reg && pending)) // R12 R13
      count_next = 4'(PULSE_CYCLES);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= 4'h0;
      ack_seen_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      ack_seen_reg <= ack_seen_next;
    end
  end

  assign line_n = (count_reg == 4'h0); // R12

endmodule

// file: src/pie_pkg.sv
/*
  Shared constants and types for the peripheral interrupt expander: source indices,
  peripheral vectors, CPU vector addresses and the pulse length.
  Assumes a 16-bit CPU program address bus and 16-bit peripheral vectors.
*/
package pie_pkg;

  localparam int PIE_NUM_SRC = 20;
  localparam int PIE_NUM_LINES = 3;
  localparam int PIE_VEC_W = 16;
  localparam int PIE_LINE_PULSE_CYCLES = 2;

  // cpu vector addresses of the fixed entries and the three mapped lines
  localparam logic [15:0] PIE_RESET_VEC = 16'h0000;
  localparam logic [15:0] PIE_EMU_TRAP_VEC = 16'h0026;
  localparam logic [15:0] PIE_NMI_VEC = 16'h0024;
  localparam logic [15:0] PIE_LINE_FIRST_VEC = 16'h0002;
  localparam logic [15:0] PIE_LINE_SECOND_VEC = 16'h0004;
  localparam logic [15:0] PIE_LINE_THIRD_VEC = 16'h0006;
  localparam logic [15:0] PIE_PHANTOM_VEC = 16'h0000;
  localparam logic [15:0] PIE_VECTOR_RESET = 16'h0000;

  // bit positions: 0..15 are request word 0, 16..19 are request word 1 bits 0..3
  localparam int PIE_BIT_POWER_PROTECT = 0;
  localparam int PIE_BIT_CONVERTER = 1;
  localparam int PIE_BIT_EXT_A = 2;
  localparam int PIE_BIT_EXT_B = 3;
  localparam int PIE_BIT_SPI = 4;
  localparam int PIE_BIT_SCI_RX = 5;
  localparam int PIE_BIT_SCI_TX = 6;
  localparam int PIE_BIT_CAN_MBOX = 7;
  localparam int PIE_BIT_CAN_ERR = 8;
  localparam int PIE_BIT_CMP_A = 9;
  localparam int PIE_BIT_CMP_B = 10;
  localparam int PIE_BIT_CMP_C = 11;
  localparam int PIE_BIT_TA_PERIOD = 12;
  localparam int PIE_BIT_TA_COMPARE = 13;
  localparam int PIE_BIT_TA_UNDER = 14;
  localparam int PIE_BIT_TA_OVER = 15;
  localparam int PIE_BIT_TB_PERIOD = 16;
  localparam int PIE_BIT_TB_COMPARE = 17;
  localparam int PIE_BIT_TB_UNDER = 18;
  localparam int PIE_BIT_TB_OVER = 19;

  // line ranges over the flattened bit index; lower index is more urgent
  localparam int PIE_FIRST_LO = 0;
  localparam int PIE_FIRST_HI = 8;
  localparam int PIE_SECOND_LO = 9;
  localparam int PIE_SECOND_HI = 15;
  localparam int PIE_THIRD_LO = 16;
  localparam int PIE_THIRD_HI = 19;

  // overall priority of bit 0; bit n has priority PIE_PRIO_BASE + n
  localparam int PIE_PRIO_BASE = 4;

  localparam logic [15:0] PIE_PERIPH_VEC [PIE_NUM_SRC] = '{
    16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007, 16'h0040,
    16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002A,
    16'h002B, 16'h002C, 16'h002D, 16'h002E
  };

  typedef struct packed {
    logic power_protect_irq;
    logic converter_irq;
    logic ext_pin_irq_a;
    logic ext_pin_irq_b;
    logic spi_irq;
    logic sci_receive_irq;
    logic sci_transmit_irq;
    logic can_mailbox_irq;
    logic can_error_irq;
    logic compare_a_irq;
    logic compare_b_irq;
    logic compare_c_irq;
    logic timer_a_period_irq;
    logic timer_a_compare_irq;
    logic timer_a_underflow_irq;
    logic timer_a_overflow_irq;
    logic timer_b_period_irq;
    logic timer_b_compare_irq;
    logic timer_b_underflow_irq;
    logic timer_b_overflow_irq;
  } pie_src_type;

  typedef struct packed {
    logic valid;
    logic [15:0] address;
  } pie_ack_type;

endpackage

// file: src/pie_winner.sv
/*
  Fixed-priority picker over one line's slice of the request bits: returns the
  lowest set index inside [LO, HI] and whether any bit there is set.
  Assumes LO <= HI < PIE_NUM_SRC.
*/
`timescale 1ns/10ps
module pie_winner
  import pie_pkg::*;
#(
  parameter int LO = 0,
  parameter int HI = 0
)
(
  input wire logic [PIE_NUM_SRC-1:0] req,
  output logic any,
  output logic [4:0] index
);

  initial
  begin
    if (LO > HI || HI >= PIE_NUM_SRC)
      $error("pie_winner: bad range");
  end

  always_comb
  begin
    any = 1'b0;
    index = 5'h00;
    for (int i = HI; i >= LO; i--) // R11
    begin
      if (req[i])
      begin
        any = 1'b1;
        index = 5'(i);
      end
    end
  end

endmodule

// file: test/pie_controller_checker.sv
/*
  Port checker for pie_controller.
  Assumes it is bound to every pie_controller and sees only its ports.
*/
`timescale 1ns/10ps
module pie_controller_checker
  import pie_pkg::*;
#(
  parameter int PULSE_CYCLES = PIE_LINE_PULSE_CYCLES
)
(
  input logic CORE_CLK,
  input logic RST_N,
  input pie_ack_type CPU_ACK,
  input logic CPU_LINE_FIRST_N,
  input logic CPU_LINE_SECOND_N,
  input logic CPU_LINE_THIRD_N,
  input logic [PIE_NUM_SRC-1:0] PERIPHERAL_REQUEST_BITS,
  input logic [PIE_NUM_SRC-1:0] PERIPHERAL_ACK_BITS,
  input logic [PIE_VEC_W-1:0] VECTOR_READBACK_REG,
  input logic ACK_LINE_FIXED
);
  logic [19:0] m;
  logic [19:0] p;
  logic [4:0] win;
  logic [2:0] low_cnt_reg;
  logic [2:0] low_cnt_next;
  logic [2:0] low_b_cnt_reg;
  logic [2:0] low_b_cnt_next;
  logic [2:0] low_c_cnt_reg;
  logic [2:0] low_c_cnt_next;
  assign m = (CPU_ACK.address == 16'h0002) ? 20'h001FF : (CPU_ACK.address == 16'h0004) ?
    20'h0FE00 : (CPU_ACK.address == 16'h0006) ? 20'hF0000 : 20'h00000;
  assign p = PERIPHERAL_REQUEST_BITS & m;
  always_comb
  begin
    win = 5'h0;
    low_cnt_next = CPU_LINE_FIRST_N ? 3'h0 : low_cnt_reg + 3'h1;
    low_b_cnt_next = CPU_LINE_SECOND_N ? 3'h0 : low_b_cnt_reg + 3'h1;
    low_c_cnt_next = CPU_LINE_THIRD_N ? 3'h0 : low_c_cnt_reg + 3'h1;
    for (int i = 19; i >= 0; i--)
      if (p[i])
        win = 5'(i);
  end
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
    begin
      low_cnt_reg <= 3'h0;
      low_b_cnt_reg <= 3'h0;
      low_c_cnt_reg <= 3'h0;
    end
    else
    begin
      low_cnt_reg <= low_cnt_next;
      low_b_cnt_reg <= low_b_cnt_next;
      low_c_cnt_reg <= low_c_cnt_next;
    end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  vec_load_a:
    assert property (CPU_ACK.valid && p != 0 |=> VECTOR_READBACK_REG == PIE_PERIPH_VEC[$past(win)])
    else $error("wrong vector loaded");
  ack_bit_a:
    assert property (CPU_ACK.valid && p != 0 |=> PERIPHERAL_ACK_BITS == 20'h1 << $past(win))
    else $error("wrong ack bit");
  phantom_vec_a:
    assert property (CPU_ACK.valid && m != 0 && p == 0 |=>
      VECTOR_READBACK_REG == 16'h0000 && PERIPHERAL_ACK_BITS == 20'h0)
    else $error("phantom ack wrong");
  fixed_entry_a:
    assert property (CPU_ACK.valid && CPU_ACK.address inside {16'h0000, 16'h0024, 16'h0026}
      |=> ACK_LINE_FIXED && $stable(VECTOR_READBACK_REG))
    else $error("fixed ack wrong");
  no_ack_a:
    assert property (!CPU_ACK.valid |=> !ACK_LINE_FIXED && PERIPHERAL_ACK_BITS == 20'h0)
    else $error("ack output without ack");
  pulse_len_a:
    assert property ($rose(CPU_LINE_FIRST_N) |-> low_cnt_reg == PULSE_CYCLES)
    else $error("pulse length wrong");
  pulse_len_b_a:
    assert property ($rose(CPU_LINE_SECOND_N) |-> low_b_cnt_reg == PULSE_CYCLES)
    else $error("second line pulse length wrong");
  pulse_len_c_a:
    assert property ($rose(CPU_LINE_THIRD_N) |-> low_c_cnt_reg == PULSE_CYCLES)
    else $error("third line pulse length wrong");
  pulse_start_a:
    assert property (|(PERIPHERAL_REQUEST_BITS[8:0] & ~$past(PERIPHERAL_REQUEST_BITS[8:0])) &&
      CPU_LINE_FIRST_N && $past(CPU_LINE_FIRST_N) |=> !CPU_LINE_FIRST_N)
    else $error("no pulse on request");
  repulse_ack_a:
    assert property (CPU_ACK.valid && CPU_ACK.address == 16'h0002 && CPU_LINE_FIRST_N &&
      $countones(PERIPHERAL_REQUEST_BITS[8:0]) > 1 |-> ##[1:4] !CPU_LINE_FIRST_N)
    else $error("no pulse after ack");
  cover property (CPU_ACK.valid && p != 0);
  cover property (CPU_ACK.valid && m != 0 && p == 0);
  cover property (ACK_LINE_FIXED);
  cover property (|(PERIPHERAL_REQUEST_BITS[8:0] & ~$past(PERIPHERAL_REQUEST_BITS[8:0])) &&
    |$past(PERIPHERAL_REQUEST_BITS[8:0]));
endmodule
bind pie_controller pie_controller_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_pie_controller_checker
  (.*);

// file: test/pie_cpu_model.sv
/*
  CPU side model: acknowledges each pulsed line after lat idle cycles, or on inj.
  Assumes line_n bit 0 is the first line.
*/
`timescale 1ns/10ps
module pie_cpu_model
  import pie_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [2:0] line_n,
  input logic [3:0] lat,
  input logic inj,
  input logic [15:0] inj_addr,
  output pie_ack_type ack
);
  logic [2:0] seen = 3'h0;
  logic [2:0] prev = 3'h7;
  int cnt = 0;
  logic s_inj;
  logic s_rst_n;
  logic [3:0] s_lat;
  logic [15:0] s_addr;
  initial
  begin
    ack = '0;
    forever
    begin
      @(posedge clk);
      // controls are taken at the edge, where the bench never changes them
      s_inj = inj;
      s_addr = inj_addr;
      s_lat = lat;
      s_rst_n = rst_n;
      #1;
      seen = s_rst_n ? seen | (prev & ~line_n) : 3'h0;
      prev = line_n;
      // acks only with all lines idle, like a core that takes the pulse first
      cnt = (seen != 3'h0 && line_n == 3'h7) ? cnt + 1 : 0;
      ack.valid = s_inj || cnt > s_lat;
      if (s_inj)
        ack.address = s_addr;
      else if (cnt > s_lat)
      begin
        ack.address = seen[0] ? 16'h0002 : seen[1] ? 16'h0004 : 16'h0006;
        seen = seen & (seen - 3'h1);
        cnt = 0;
      end
      else
        ack.address = ~ack.address;
    end
  end
endmodule

// file: test/tb.sv
/*
  Self-checking bench for pie_controller with a CPU side model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
module tb;
  import pie_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic inj = 1'b0;
  logic [19:0] src = 20'h0;
  logic [7:0] hp = 8'h0;
  logic [3:0] lat = 4'h0;
  logic [15:0] inj_addr = 16'h0;
  logic [15:0] last_vec = 16'h0;
  logic [15:0] tbl [7] = '{16'h0002, 16'h0004, 16'h0006, 16'h0000, 16'h0024, 16'h0026, 16'h0008};
  logic [2:0] lines;
  logic [19:0] rbits;
  logic [19:0] abits;
  logic [15:0] vec;
  logic fixed;
  pie_ack_type ack;
  pie_src_type psrc;
  int n_fail = 0;
  int n_checks = 0;
  logic [36:0] notes [$];
  assign psrc = {<<{src}};
  pie_controller u_pie_controller (.CORE_CLK(clk), .RST_N(rst_n), .PERIPH_REQ(psrc),
    .HP_CONVERTER(hp[0]), .HP_EXT_A(hp[1]), .HP_EXT_B(hp[2]), .HP_SPI(hp[3]),
    .HP_SCI_RX(hp[4]), .HP_SCI_TX(hp[5]), .HP_CAN_MBOX(hp[6]), .HP_CAN_ERR(hp[7]),
    .CPU_ACK(ack), .CPU_LINE_FIRST_N(lines[0]), .CPU_LINE_SECOND_N(lines[1]),
    .CPU_LINE_THIRD_N(lines[2]), .PERIPHERAL_REQUEST_BITS(rbits),
    .PERIPHERAL_ACK_BITS(abits), .VECTOR_READBACK_REG(vec), .ACK_LINE_FIXED(fixed));
  pie_cpu_model u_pie_cpu_model (.clk(clk), .rst_n(rst_n), .line_n(lines), .lat(lat),
    .inj(inj), .inj_addr(inj_addr), .ack(ack));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [19:0] gated();
    return src & {11'h7FF, hp, 1'b1};
  endfunction
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // peripherals drop a request in the cycle its ack bit shows
  task automatic step(logic [19:0] s = 20'h0, logic [19:0] k = 20'hFFFFF);
    @(posedge clk);
    `CHK(rbits, gated())
    #1;
    src = (src & ~abits & k) | s;
  endtask
  task automatic drain();
    for (int t = 0; t < 300 && gated() != 20'h0; t++)
      step();
    if (gated() != 20'h0)
    begin
      n_fail++;
      conclude();
    end
    repeat (12) step();
  endtask
  always @(posedge clk)
    if (ack.valid)
    begin : note
      logic [19:0] m;
      logic [36:0] e;
      m = (ack.address == 16'h0002) ? 20'h001FF : (ack.address == 16'h0004) ? 20'h0FE00 :
        (ack.address == 16'h0006) ? 20'hF0000 : 20'h0;
      e = {ack.address inside {16'h0000, 16'h0024, 16'h0026}, 20'h0, m == 0 ? last_vec : 16'h0};
      m = m & gated();
      for (int i = 19; i >= 0; i--)
        if (m[i])
          e[35:0] = {20'h1 << i, PIE_PERIPH_VEC[i]};
      last_vec = e[15:0];
      notes.push_back(e);
    end
  // ack outputs stand for the one cycle after the edge that takes the ack
  always @(posedge clk)
  begin : watch
    logic [36:0] e;
    if (ack.valid)
    begin
      #2;
      if (notes.size() == 0)
      begin
        n_fail++;
        $display("BAD %0t no note for ack", $time);
      end
      else
      begin
        e = notes.pop_front();
        `CHK({fixed, abits, vec}, e)
      end
    end
  end
  initial
  begin
    void'($urandom(73621));
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) step();
    `CHK({lines, abits, vec, fixed}, {3'h7, 20'h0, PIE_VECTOR_RESET, 1'b0})
    hp = 8'hFF;
    for (int i = 0; i < 20; i++)
    begin
      lat = 4'(i % 5);
      step(20'h1 << i);
      drain();
    end
    for (int r = 0; r < 16; r++)
    begin
      hp = 8'($urandom);
      lat = 4'($urandom % 7);
      step(20'($urandom));
      drain();
      step(20'h0, 20'h0);
    end
    // a second request joins line one while the first still waits for its ack
    hp = 8'hFF;
    lat = 4'h6;
    step(20'h2);
    repeat (4) step();
    step(20'h4);
    drain();
    // flag cleared by software before the ack arrives
    lat = 4'h9;
    step(20'h1 << 16);
    step(20'h0, 20'h0);
    repeat (20) step();
    for (int j = 0; j < 7; j++)
    begin
      inj_addr = tbl[j];
      inj = 1'b1;
      step();
      inj = 1'b0;
      repeat (2) step();
    end
    conclude();
  end
endmodule
